// ---- rtl/crm_defines.vh ----
// Purpose: Constants for the configuration message interpreter.
// Assumes: Tokens are 8 bits wide with a control flag beside them.
// Notes: Included by every design file of the block.
`ifndef CRM_DEFINES_VH
`define CRM_DEFINES_VH
`define CRM_TOK_WRITE 8'hC0
`define CRM_TOK_READ 8'hC1
`define CRM_TOK_END 8'h01
`define CRM_TOK_ACK 8'h03
`define CRM_TOK_NACK 8'h04
`define CRM_NOREPLY_LOW 8'hFF
`define CRM_PS_RES_LOW 8'h0B
`define CRM_PS_SHIFT 8
`define CRM_DBG_LO 16'h0010
`define CRM_DBG_HI 16'h00FF
`endif

// ---- rtl/crm_tx.v ----
// Purpose: Serialises a reply message into tokens, one per accepted cycle.
// Assumes: The caller loads a reply only while tx_idle is high.
// Notes: Data bytes leave most significant byte first.
`timescale 1ns/1ps
`default_nettype none
`include "crm_defines.vh"
module crm_tx (
    input wire clk,
    input wire sys_rst,
    input wire load,
    input wire ok,
    input wire with_data,
    input wire [31:0] data,
    input wire [23:0] dest,
    input wire out_ready,
    output reg out_valid,
    output reg out_ctrl,
    output reg [7:0] out_token,
    output reg [23:0] out_dest,
    output wire tx_idle
);
    reg [2:0] left;
    reg [31:0] shreg;
    reg data_phase;
    assign tx_idle = (left == 3'd0) && !out_valid;
    always @(posedge clk) begin
        if (sys_rst) begin
            left <= 3'd0;
            shreg <= 32'h0000_0000;
            data_phase <= 1'b0;
            out_valid <= 1'b0;
            out_ctrl <= 1'b0;
            out_token <= 8'h00;
            out_dest <= 24'h00_0000;
        end else if (load) begin
            out_valid <= 1'b1;
            out_ctrl <= 1'b1;
            out_token <= ok ? `CRM_TOK_ACK : `CRM_TOK_NACK;
            out_dest <= dest;
            shreg <= data;
            data_phase <= ok && with_data;
            left <= (ok && with_data) ? 3'd5 : 3'd1;
        end else if (out_valid && out_ready) begin
            if (left == 3'd0) begin
                out_valid <= 1'b0;
            end else if (data_phase && left > 3'd1) begin
                out_ctrl <= 1'b0;
                out_token <= shreg[31:24];
                shreg <= {shreg[23:0], 8'h00};
                left <= left - 3'd1;
            end else begin
                out_ctrl <= 1'b1;
                out_token <= `CRM_TOK_END;
                left <= 3'd0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/crm_interp.v ----
// Purpose: Decodes configuration access messages and answers them.
// Assumes: Tokens come from the local interconnect on the same clock.
// Notes: Register storage lives outside; this block drives its port.
// Notes on behaviour
// RULE1: Each request carries a 24-bit reply channel-end address.
// RULE2: Write with reply address low byte all ones gets no reply.
// RULE3: Multi-byte fields travel most significant byte first.
// RULE4: Status resource id is register number shifted left 8, OR 0x0B; the code keeps only the low byte of the 16-bit number.
// RULE5: Status read and write move one full 32-bit word.
// RULE6: Tile bank is reached at tile id followed by c20c.
// RULE7: Node bank is reached at node id followed by c30c.
// RULE8: Write is token 192, address, 16-bit number, 32-bit data, token 1.
// RULE9: Write reply is tokens 3,1 on success or 4,1 on failure.
// RULE10: Read is token 193, address, 16-bit number, token 1.
// RULE11: Read reply is 3, data word, 1; or 4, 1 on failure.
// RULE12: Debug-only registers accept access only in debug mode.
// RULE13: Reply goes to the channel-end named in the request.
`timescale 1ns/1ps
`default_nettype none
`include "crm_defines.vh"
module crm_interp (
    input wire clk,
    input wire sys_rst,
    input wire in_valid,
    input wire in_ctrl,
    input wire [7:0] in_token,
    output wire in_ready,
    input wire debug_mode,
    output reg reg_wr,
    output reg reg_rd,
    output reg [15:0] reg_num,
    output reg [31:0] reg_wdata,
    output reg [15:0] ps_res_id,
    input wire [31:0] reg_rdata,
    input wire reg_err,
    output wire out_valid,
    output wire out_ctrl,
    output wire [7:0] out_token,
    output wire [23:0] out_dest,
    input wire out_ready
);
    localparam ST_CMD = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_NUM = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_END = 3'd4;
    localparam ST_EXEC = 3'd5;
    localparam ST_REPLY = 3'd6;
    localparam ST_DROP = 3'd7;
    reg [2:0] state;
    reg [2:0] cnt;
    reg is_write;
    reg bad;
    reg [23:0] reply_addr;
    reg [31:0] rdata;
    reg ok;
    reg tx_load;
    reg acc_wr;
    reg acc_rd;
    wire tx_idle;
    wire dbg_reg;
    wire tok_write;
    wire tok_read;
    wire tok_end;
    wire no_reply;
    wire access_ok;
    // Input stalls while a request executes and its reply is queued.
    assign in_ready = (state != ST_EXEC) && (state != ST_REPLY);
    // Numbers in this range are debug-only in this design.
    assign dbg_reg = (reg_num >= `CRM_DBG_LO) && (reg_num <= `CRM_DBG_HI);
    assign tok_write = in_valid && in_ctrl && in_token == `CRM_TOK_WRITE;
    assign tok_read = in_valid && in_ctrl && in_token == `CRM_TOK_READ;
    assign tok_end = in_valid && in_ctrl && in_token == `CRM_TOK_END;
    // Only writes may ask for silence; a read always answers.
    assign no_reply = is_write && reply_addr[7:0] == `CRM_NOREPLY_LOW;
    assign access_ok = !(dbg_reg && !debug_mode);
    always @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_CMD;
            cnt <= 3'd0;
            is_write <= 1'b0;
            bad <= 1'b0;
            reply_addr <= 24'h00_0000;
            reg_num <= 16'h0000;
            reg_wdata <= 32'h0000_0000;
            ps_res_id <= 16'h0000;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            rdata <= 32'h0000_0000;
            ok <= 1'b0;
            tx_load <= 1'b0;
            acc_wr <= 1'b0;
            acc_rd <= 1'b0;
        end else begin
            acc_wr <= reg_wr;
            acc_rd <= reg_rd;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            tx_load <= 1'b0;
            case (state)
            ST_CMD: begin
                if (tok_write) begin
                    is_write <= 1'b1; // RULE8
                    bad <= 1'b0;
                    cnt <= 3'd0;
                    state <= ST_ADDR;
                end else if (tok_read) begin
                    is_write <= 1'b0; // RULE10
                    bad <= 1'b0;
                    cnt <= 3'd0;
                    state <= ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (in_valid) begin
                    reply_addr <= {reply_addr[15:0], in_token}; // RULE3
                    bad <= bad | in_ctrl;
                    cnt <= cnt + 3'd1;
                    if (cnt == 3'd2) begin
                        cnt <= 3'd0;
                        state <= ST_NUM;
                    end
                end
            end
            ST_NUM: begin
                if (in_valid) begin
                    reg_num <= {reg_num[7:0], in_token}; // RULE3
                    bad <= bad | in_ctrl;
                    cnt <= cnt + 3'd1;
                    if (cnt == 3'd1) begin
                        cnt <= 3'd0;
                        state <= is_write ? ST_DATA : ST_END;
                    end
                end
            end
            ST_DATA: begin
                if (in_valid) begin
                    reg_wdata <= {reg_wdata[23:0], in_token}; // RULE3
                    bad <= bad | in_ctrl;
                    cnt <= cnt + 3'd1;
                    if (cnt == 3'd3) begin
                        cnt <= 3'd0;
                        state <= ST_END;
                    end
                end
            end
            ST_END: begin
                if (in_valid) begin
                    ps_res_id <= {reg_num[7:0], `CRM_PS_RES_LOW}; // RULE4
                    if (tok_end && !bad) begin
                        state <= ST_EXEC;
                    end else begin
                        // A control token inside a field earns a 4,1 reply, unless a write asks for no reply.
                        ok <= 1'b0;
                        if (tok_end) begin
                            state <= ST_REPLY;
                        end else begin
                            state <= ST_DROP;
                        end
                    end
                end
            end
            ST_EXEC: begin
                if (!access_ok) begin
                    // A refused access leaves every register untouched.
                    ok <= 1'b0; // RULE12
                end else begin
                    reg_wr <= is_write; // RULE5
                    reg_rd <= !is_write; // RULE5
                    ok <= 1'b1;
                end
                state <= ST_REPLY;
            end
            ST_REPLY: begin
                if (reg_rd || reg_wr) begin
                    // The bank answers in the cycle after the pulse.
                    state <= ST_REPLY;
                end else if (acc_rd) begin
                    rdata <= reg_rdata; // RULE11
                    ok <= ok & !reg_err;
                end else if (acc_wr) begin
                    ok <= ok & !reg_err; // RULE9
                end else if (tx_idle) begin
                    // The reply waits until the previous one has left.
                    if (no_reply) begin
                        state <= ST_CMD; // RULE2
                    end else begin
                        tx_load <= 1'b1;
                        state <= ST_CMD;
                    end
                end
            end
            ST_DROP: begin
                if (tok_end) begin
                    state <= ST_REPLY;
                end
            end
            default: begin
                state <= ST_CMD;
            end
            endcase
        end
    end
    crm_tx u_tx (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(tx_load),
        .ok(ok),
        .with_data(!is_write),
        .data(rdata),
        .dest(reply_addr), // RULE13
        .out_ready(out_ready),
        .out_valid(out_valid),
        .out_ctrl(out_ctrl),
        .out_token(out_token),
        .out_dest(out_dest),
        .tx_idle(tx_idle)
    );
endmodule
`default_nettype wire

// ---- verif/crm_bank.sv ----
// Purpose: Register bank model behind the interpreter.
// Assumes: Read data and error are due the cycle after a pulse.
// Notes: Register number BAD_NUM always fails.
`timescale 1ns/1ps
`default_nettype none
module crm_bank #(parameter logic [15:0] BAD_NUM = 16'h0100) (
    input wire logic clk,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_num,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_err
);
    logic [31:0] mem [0:255];
    always @(posedge clk) begin
        reg_err <= (reg_wr || reg_rd) && reg_num == BAD_NUM;
        if (reg_wr) begin
            mem[reg_num[7:0]] <= reg_wdata;
        end
        reg_rdata <= reg_rd ? mem[reg_num[7:0]] : ~reg_rdata;
    end
endmodule
`default_nettype wire

// ---- verif/crm_interp_properties.sv ----
// Purpose: Port checker for the message interpreter.
// Assumes: One clock, synchronous reset.
// Notes: Attached by bind from the bench.
`timescale 1ns/1ps
`default_nettype none
module crm_interp_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    input wire logic in_ctrl,
    input wire logic [7:0] in_token,
    input wire logic in_ready,
    input wire logic debug_mode,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_num,
    input wire logic [15:0] ps_res_id,
    input wire logic out_valid,
    input wire logic out_ctrl,
    input wire logic [7:0] out_token,
    input wire logic [23:0] out_dest,
    input wire logic out_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_wr; reg_wr |=> !reg_wr; endproperty
    a_wr: assert property (p_wr) else $error("long write");
    property p_rd; reg_rd |=> !reg_rd; endproperty
    a_rd: assert property (p_rd) else $error("long read");
    property p_ps; reg_wr || reg_rd |-> ps_res_id == {reg_num[7:0], 8'h0B};
    endproperty
    a_ps: assert property (p_ps) else $error("bad status id");
    property p_dbg; (reg_wr || reg_rd) && !debug_mode
        |-> reg_num < 16'h0010 || reg_num > 16'h00FF; endproperty
    a_dbg: assert property (p_dbg) else $error("debug access");
    property p_hold; out_valid && !out_ready
        |=> out_valid && $stable({out_ctrl, out_token, out_dest}); endproperty
    a_hold: assert property (p_hold) else $error("reply moved");
    property p_ans; reg_rd |-> ##4 out_valid && out_ctrl
        && (out_token == 8'h03 || out_token == 8'h04); endproperty
    a_ans: assert property (p_ans) else $error("no read reply");
    property p_nack; out_valid && out_ready && out_ctrl && out_token == 8'h04
        |=> ##[0:3] out_valid && out_ctrl && out_token == 8'h01; endproperty
    a_nack: assert property (p_nack) else $error("no end token");
    property p_busy; in_valid && in_ready && in_ctrl && in_token == 8'h01
        |=> !in_ready; endproperty
    a_busy: assert property (p_busy) else $error("ready after end");
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the message interpreter.
// Assumes: Inputs change on the falling edge.
// Notes: Bank model supplies register storage.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, sys_rst = 1, in_valid = 0, in_ctrl = 0;
    logic debug_mode = 0, out_ready = 1;
    logic [7:0] in_token = 0;
    wire in_ready, reg_wr, reg_rd, reg_err, out_valid, out_ctrl;
    wire [7:0] out_token;
    wire [15:0] reg_num, ps_res_id;
    wire [31:0] reg_wdata, reg_rdata;
    wire [23:0] out_dest;
    int num_errors = 0, compares = 0;
    crm_interp u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(in_valid),
        .in_ctrl(in_ctrl),
        .in_token(in_token),
        .in_ready(in_ready),
        .debug_mode(debug_mode),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_num(reg_num),
        .reg_wdata(reg_wdata),
        .ps_res_id(ps_res_id),
        .reg_rdata(reg_rdata),
        .reg_err(reg_err),
        .out_valid(out_valid),
        .out_ctrl(out_ctrl),
        .out_token(out_token),
        .out_dest(out_dest),
        .out_ready(out_ready)
    );
    crm_bank u_bank (
        .clk(clk),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_num(reg_num),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_err(reg_err)
    );
    always #2 clk = ~clk;
    task automatic print_verdict();
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic c, input logic [7:0] t);
        int n = 0;
        @(negedge clk);
        in_valid = 1;
        in_ctrl = c;
        in_token = t;
        while (!in_ready && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n >= 50) begin
            num_errors++;
            $display("wrong value at %0t: input never ready", $time);
            print_verdict();
        end
        @(posedge clk);
    endtask
    task automatic req(input logic [7:0] cmd, input logic [23:0] a,
                       input logic [15:0] r, input logic [31:0] d);
        logic [71:0] f;
        f = {a, r, d};
        put(1, cmd);
        for (int i = 0; i < (cmd == 8'hC1 ? 5 : 9); i++) begin
            put(0, f[71-8*i -: 8]);
        end
        put(1, 8'h01);
        @(negedge clk);
        in_valid = 0;
    endtask
    task automatic get(input logic c, input logic [7:0] t,
                       input logic [23:0] a);
        int n = 0;
        while (!out_valid && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n >= 50) begin
            num_errors++;
            $display("wrong value at %0t: no reply token", $time);
            print_verdict();
        end
        check({out_ctrl, out_token}, {c, t});
        check(out_dest, a);
        @(negedge clk);
    endtask
    task automatic ack(input logic [7:0] t, input logic [23:0] a);
        get(1, t, a);
        get(1, 8'h01, a);
    endtask
    task automatic t_write_read();
        logic [31:0] w;
        w = 32'hA1B2_C3D4;
        req(8'hC0, 24'h12_3456, 16'h0005, w);
        ack(8'h03, 24'h12_3456);
        check(u_bank.mem[5], w);
        req(8'hC1, 24'h65_4321, 16'h0005, 0);
        out_ready = 0;
        repeat (6) @(negedge clk);
        out_ready = 1;
        get(1, 8'h03, 24'h65_4321);
        for (int i = 3; i >= 0; i--) begin
            get(0, w[8*i +: 8], 24'h65_4321);
        end
        get(1, 8'h01, 24'h65_4321);
    endtask
    task automatic t_silent();
        req(8'hC0, 24'hAB_CDFF, 16'h0006, 32'h0BAD_F00D);
        repeat (12) begin
            @(negedge clk);
            check(out_valid, 0);
        end
        check(u_bank.mem[6], 32'h0BAD_F00D);
    endtask
    task automatic t_debug();
        debug_mode = 1;
        req(8'hC0, 24'h00_0100, 16'h0010, 32'h1111_2222);
        ack(8'h03, 24'h00_0100);
        debug_mode = 0;
        req(8'hC0, 24'h00_0100, 16'h0010, 32'h3333_4444);
        ack(8'h04, 24'h00_0100);
        req(8'hC1, 24'h00_0100, 16'h0010, 0);
        ack(8'h04, 24'h00_0100);
        check(u_bank.mem[16], 32'h1111_2222);
    endtask
    task automatic t_fail();
        req(8'hC1, 24'h00_0200, 16'h0100, 0);
        ack(8'h04, 24'h00_0200);
        req(8'hC0, 24'h00_0300, 16'h0100, 32'h0000_0005);
        ack(8'h04, 24'h00_0300);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 0;
        t_write_read();
        t_silent();
        t_debug();
        t_fail();
        print_verdict();
    end
endmodule
bind crm_interp crm_interp_properties u_chk (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(in_valid),
    .in_ctrl(in_ctrl),
    .in_token(in_token),
    .in_ready(in_ready),
    .debug_mode(debug_mode),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_num(reg_num),
    .ps_res_id(ps_res_id),
    .out_valid(out_valid),
    .out_ctrl(out_ctrl),
    .out_token(out_token),
    .out_dest(out_dest),
    .out_ready(out_ready)
);
`default_nettype wire
